// file: core/bdm_core.sv
// banked data memory with bank select, mirrors, common area, indirection
// assumes one clock, an AXI4-Lite master that keeps valid/payload steady
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1: status bits six and five pick bank 0 to 3 for direct accesses.
// RULE2: each bank holds 128 byte locations at offsets 00h to 7Fh.
// RULE3: low offsets of each bank are special registers, those above are RAM.
// RULE4: busy special registers answer from one place in every bank.
// RULE5: a location is reached directly or through the indirect pointer.
// RULE6: software keeps the reserved top-bank locations at zero.
// RULE7: offsets 70h to 7Fh of banks 1 to 3 reach bank 0 RAM.
module bdm_core
  import bdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [BDM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [BDM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] bank_o
);

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] mem_q [BDM_MEM_DEPTH];
  logic [7:0] status_q, ptr_q, w_data_q;
  bdm_ch_t wst_q, rst_q;
  logic [BDM_AW-1:0] aw_addr_q;
  logic w_lane_q, aw_have_q, w_have_q;
  logic aw_ready_q, w_ready_q, ar_ready_q;
  logic [1:0] bresp_q, rresp_q;
  logic bvalid_q, rvalid_q;
  logic [31:0] rdata_q;
  assign s_axi_awready = aw_ready_q;
  assign s_axi_wready = w_ready_q;
  assign s_axi_arready = ar_ready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign bank_o = {status_q[BDM_BSEL_HI_BIT], status_q[BDM_BSEL_LO_BIT]};

  ////////////////////////////////////////////////////////////////////////
  // address decode
  // registers kept once and seen from every bank
  function automatic logic is_mirror(input logic [6:0] off);
    is_mirror = (off == BDM_IND_OFF) || (off == BDM_PCL_OFF) ||
                (off == BDM_STATUS_OFF) || (off == BDM_PTR_OFF) ||
                (off == BDM_PCLATH_OFF) || (off == BDM_INTCON_OFF); // RULE4
  endfunction
  // bank plus 7-bit offset to one physical location
  function automatic bdm_acc_t map_loc(input logic [1:0] bank,
                                       input logic [6:0] off);
    bdm_acc_t a;
    a = '0;
    a.is_status = (off == BDM_STATUS_OFF);
    a.is_ptr = (off == BDM_PTR_OFF);
    a.is_null = (off == BDM_IND_OFF);
    // mirrored sfrs and the common area map to bank 0, everything else to the given bank
    if (is_mirror(off) || off >= BDM_COMMON_LO) begin // RULE7 RULE3
      a.phys = {BDM_BANK0, off}; // RULE4
    end else begin
      a.phys = {bank, off}; // RULE2
    end
    map_loc = a;
  endfunction
  // direct offset, or the pointer when offset 00h is named
  function automatic bdm_acc_t decode(input logic [6:0] off,
                                      input logic [7:0] st,
                                      input logic [7:0] ptr);
    if (off == BDM_IND_OFF) begin // RULE5
      // status bit 7 and pointer bit 7 pick the bank
      decode = map_loc({st[BDM_IBANK_BIT], ptr[7]}, ptr[6:0]);
    end else begin
      decode = map_loc({st[BDM_BSEL_HI_BIT], st[BDM_BSEL_LO_BIT]}, off);
    end
  endfunction

  logic [6:0] wr_off, rd_off;
  logic wr_bad, wr_fire, rd_bad, ar_fire;
  bdm_acc_t wr_acc, rd_acc;
  logic [7:0] rd_byte;
  // upper address bits outside the 128-word window are unmapped
  assign wr_off = aw_addr_q[BDM_IDX_MSB:BDM_IDX_LSB];
  assign wr_bad = |aw_addr_q[BDM_AW-1:BDM_IDX_MSB+1];
  assign wr_fire = (wst_q == BDM_CH_IDLE) && aw_have_q && w_have_q;
  assign wr_acc = decode(wr_off, status_q, ptr_q);
  assign rd_off = s_axi_araddr[BDM_IDX_MSB:BDM_IDX_LSB];
  assign rd_bad = |s_axi_araddr[BDM_AW-1:BDM_IDX_MSB+1];
  assign ar_fire = s_axi_arvalid && ar_ready_q;
  assign rd_acc = decode(rd_off, status_q, ptr_q);
  // read mux: core registers live in flops, the rest in the array
  always_comb begin
    if (rd_bad || rd_acc.is_null) begin
      rd_byte = 8'h00;
    end else if (rd_acc.is_status) begin
      rd_byte = status_q; // RULE1
    end else if (rd_acc.is_ptr) begin
      rd_byte = ptr_q; // RULE5
    end else begin
      rd_byte = mem_q[rd_acc.phys]; // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wst_q <= BDM_CH_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_ready_q <= 1'b0;
      w_ready_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= BDM_RESP_OKAY;
    end else begin
      case (wst_q)
        BDM_CH_IDLE: begin
          if (s_axi_awvalid && aw_ready_q) begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
          end
          if (s_axi_wvalid && w_ready_q) begin
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
            w_have_q <= 1'b1;
          end
          aw_ready_q <= !(aw_have_q || (s_axi_awvalid && aw_ready_q));
          w_ready_q <= !(w_have_q || (s_axi_wvalid && w_ready_q));
          if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_ready_q <= 1'b0;
            w_ready_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_bad ? BDM_RESP_SLVERR : BDM_RESP_OKAY;
            wst_q <= BDM_CH_RESP;
          end
        end
        BDM_CH_RESP: begin
          if (s_axi_bready) begin
            bvalid_q <= 1'b0;
            wst_q <= BDM_CH_IDLE;
          end
        end
        default: begin
          wst_q <= BDM_CH_IDLE;
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end
  // core register updates; lane 0 carries the only byte
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_q <= BDM_STATUS_RST;
      ptr_q <= BDM_PTR_RST;
    end else if (wr_fire && !wr_bad && w_lane_q) begin
      if (wr_acc.is_status) begin
        status_q <= w_data_q; // RULE1
      end
      if (wr_acc.is_ptr) begin
        ptr_q <= w_data_q; // RULE5
      end
    end
  end
  // array write; no reset, ram content is undefined at power up
  always_ff @(posedge clk_i) begin
    if (wr_fire && !wr_bad && w_lane_q && !wr_acc.is_null &&
        !wr_acc.is_status && !wr_acc.is_ptr) begin
      mem_q[wr_acc.phys] <= w_data_q; // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel: data sampled in the accepting cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q <= BDM_CH_IDLE;
      ar_ready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= BDM_ZERO32;
      rresp_q <= BDM_RESP_OKAY;
    end else begin
      case (rst_q)
        BDM_CH_IDLE: begin
          ar_ready_q <= !ar_fire;
          if (ar_fire) begin
            rdata_q <= {24'h000000, rd_byte};
            rresp_q <= rd_bad ? BDM_RESP_SLVERR : BDM_RESP_OKAY;
            rvalid_q <= 1'b1;
            rst_q <= BDM_CH_RESP;
          end
        end
        BDM_CH_RESP: begin
          if (s_axi_rready) begin
            rvalid_q <= 1'b0;
            ar_ready_q <= 1'b1;
            rst_q <= BDM_CH_IDLE;
          end
        end
        default: begin
          rst_q <= BDM_CH_IDLE;
          rvalid_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_bank_follow;
    @(posedge clk_i) disable iff (!rstn_i)
    wr_fire && !wr_bad && w_lane_q && wr_acc.is_status |=>
      bank_o == $past({w_data_q[BDM_BSEL_HI_BIT],
                       w_data_q[BDM_BSEL_LO_BIT]});
  endproperty
  a_bank_follow: assert property (p_bank_follow) // RULE1
    else $error("bank select did not follow status write");
  property p_bad_read;
    @(posedge clk_i) disable iff (!rstn_i)
    ar_fire && rd_bad |=> rvalid_q && rresp_q == BDM_RESP_SLVERR &&
      rdata_q == BDM_ZERO32;
  endproperty
  a_bad_read: assert property (p_bad_read) // RULE2
    else $error("read outside the bank window not refused");
  property p_gpr_store;
    @(posedge clk_i) disable iff (!rstn_i)
    wr_fire && !wr_bad && w_lane_q && !wr_acc.is_null &&
      !wr_acc.is_status && !wr_acc.is_ptr |=>
      mem_q[$past(wr_acc.phys)] == $past(w_data_q);
  endproperty
  a_gpr_store: assert property (p_gpr_store) // RULE3
    else $error("file write not stored");
  property p_mirror;
    @(posedge clk_i) disable iff (!rstn_i)
    wr_fire && wr_off != BDM_IND_OFF && is_mirror(wr_off) |->
      wr_acc.phys[8:7] == BDM_BANK0;
  endproperty
  a_mirror: assert property (p_mirror) // RULE4
    else $error("mirrored register mapped per bank");
  property p_ptr_read;
    @(posedge clk_i) disable iff (!rstn_i)
    ar_fire && !rd_bad && rd_off == BDM_PTR_OFF |=>
      rvalid_q && rdata_q[7:0] == $past(ptr_q);
  endproperty
  a_ptr_read: assert property (p_ptr_read) // RULE5
    else $error("pointer read mismatch");
  property p_common;
    @(posedge clk_i) disable iff (!rstn_i)
    ar_fire && rd_off >= BDM_COMMON_LO && !rd_bad |->
      rd_acc.phys[8:7] == BDM_BANK0;
  endproperty
  a_common: assert property (p_common) // RULE7
    else $error("common area not shared with bank 0");
  property p_bresp_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");
  property p_wr_answer;
    @(posedge clk_i) disable iff (!rstn_i)
    wr_fire |=> s_axi_bvalid ##0 !s_axi_awready [*1];
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write not answered one cycle after commit");
  property p_rd_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed before taken");
endmodule

`default_nettype wire

// file: include/bdm_pkg.sv
// package for the banked data memory block: map, fields, reset values
// assumes a 32-bit AXI4-Lite register bus, one file location per word
package bdm_pkg;
  // file offsets inside a bank, also the register index on the bus
  localparam logic [6:0] BDM_IND_OFF = 7'h00; // indirect_access_port
  localparam logic [6:0] BDM_STATUS_OFF = 7'h03; // core_status
  localparam logic [6:0] BDM_PTR_OFF = 7'h04; // indirect_pointer
  localparam logic [6:0] BDM_PCL_OFF = 7'h02;
  localparam logic [6:0] BDM_PCLATH_OFF = 7'h0a;
  localparam logic [6:0] BDM_INTCON_OFF = 7'h0b;
  localparam logic [6:0] BDM_GPR_LO = 7'h20;
  localparam logic [6:0] BDM_COMMON_LO = 7'h70;
  localparam logic [6:0] BDM_BANK_TOP = 7'h7f;
  // core_status fields
  localparam int BDM_BSEL_HI_BIT = 6; // bank_select_high
  localparam int BDM_BSEL_LO_BIT = 5; // bank_select_low
  localparam int BDM_IBANK_BIT = 7; // indirect bank high bit
  localparam logic [7:0] BDM_STATUS_RST = 8'h00;
  localparam logic [7:0] BDM_PTR_RST = 8'h00;
  localparam logic [1:0] BDM_BANK0 = 2'h0;
  // bus address layout
  localparam int BDM_AW = 12;
  localparam int BDM_IDX_LSB = 2;
  localparam int BDM_IDX_MSB = 8;
  localparam int BDM_PHYS_W = 9;
  localparam int BDM_MEM_DEPTH = 512;
  localparam logic [1:0] BDM_RESP_OKAY = 2'h0;
  localparam logic [1:0] BDM_RESP_SLVERR = 2'h2;
  localparam logic [31:0] BDM_ZERO32 = 32'h0000_0000;

  // one decoded data-memory access
  typedef struct packed {
    logic is_status;
    logic is_ptr;
    logic is_null;
    logic [BDM_PHYS_W-1:0] phys;
  } bdm_acc_t;

  typedef enum logic [1:0] {
    BDM_CH_IDLE = 2'b01,
    BDM_CH_RESP = 2'b10
  } bdm_ch_t;
endpackage

// file: verification/banked_data_memory_decode_tb.sv
// testbench for the banked data memory: table walk, then edge cases
// assumes bdm_core with an AXI4-Lite slave on one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_decode_tb import bdm_pkg::*;;
  typedef struct packed {logic wr; logic [6:0] off; logic [7:0] dat;} bdm_row_t;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, bank_o, rsp, bnk;
  logic [31:0] rdata, got;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  // a bank 1 write proves banking, banks 2 and 3 write common and mirrored slots; reserved top-bank slots untouched
  bdm_row_t rows [22] = '{
    '{1'b1, 7'h03, 8'h00}, '{1'b1, 7'h20, 8'haa}, '{1'b1, 7'h03, 8'h20},
    '{1'b1, 7'h20, 8'h55}, '{1'b1, 7'h75, 8'h77}, '{1'b0, 7'h20, 8'h55},
    '{1'b1, 7'h03, 8'h40}, '{1'b1, 7'h7f, 8'h5a}, '{1'b0, 7'h75, 8'h77},
    '{1'b1, 7'h03, 8'h60}, '{1'b1, 7'h0a, 8'h3c}, '{1'b0, 7'h7f, 8'h5a},
    '{1'b1, 7'h03, 8'h00}, '{1'b0, 7'h20, 8'haa}, '{1'b0, 7'h0a, 8'h3c},
    '{1'b1, 7'h04, 8'ha0}, '{1'b0, 7'h00, 8'h55}, '{1'b1, 7'h04, 8'h21},
    '{1'b1, 7'h00, 8'h99}, '{1'b0, 7'h21, 8'h99}, '{1'b0, 7'h04, 8'h21},
    '{1'b0, 7'h03, 8'h00}};

  bdm_core bdm_core_inst (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bank_o(bank_o));

  ////////////////////////////////////////////////////////////////////////
  // clock and a watchdog; a full run needs well under a thousand cycles
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus tasks: valid and payload held until each channel's own ready
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk_i);
      if (awvalid && awready === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // compare tasks, one per kind of result
  task automatic chk_data(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic chk_code(input logic [1:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence: table rows, the indirect bank case, then reset, refusals and the odd cases
  initial begin
    bnk = BDM_BANK0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      if (rows[i].wr) begin
        axi_wr({3'h0, rows[i].off, 2'h0}, rows[i].dat, 4'h1, rsp);
        if (rows[i].off == BDM_STATUS_OFF)
          bnk = rows[i].dat[6:5];
      end else begin
        axi_rd({3'h0, rows[i].off, 2'h0}, got, rsp);
        chk_data(got, {24'h0, rows[i].dat}, "row");
      end
      chk_code(rsp, BDM_RESP_OKAY, "row resp");
      chk_code(bank_o, bnk, "bank");
    end
    $display("table walk done");
    // status bit 7 with the pointer reaches bank 2; bank left nonzero
    axi_wr({3'h0, BDM_STATUS_OFF, 2'h0}, 8'hc0, 4'h1, rsp);
    axi_wr({3'h0, BDM_PTR_OFF, 2'h0}, 8'h20, 4'h1, rsp);
    axi_wr({3'h0, BDM_IND_OFF, 2'h0}, 8'h66, 4'h1, rsp);
    axi_rd({3'h0, BDM_GPR_LO, 2'h0}, got, rsp);
    chk_data(got, 32'h0000_0066, "indirect high bank");
    chk_code(bank_o, 2'h2, "bank before reset");
    $display("indirect bank test done");
    // reset in mid-run clears status and pointer
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk_code(bank_o, BDM_BANK0, "bank in reset");
    rstn_i <= 1'b1;
    axi_rd({3'h0, BDM_PTR_OFF, 2'h0}, got, rsp);
    chk_data(got, {24'h0, BDM_PTR_RST}, "pointer reset");
    $display("reset test done");
    // out-of-range index is refused and must not alias onto status
    axi_wr(12'h20c, 8'h60, 4'h1, rsp);
    chk_code(rsp, BDM_RESP_SLVERR, "bad write");
    axi_rd(12'h200, got, rsp);
    chk_code(rsp, BDM_RESP_SLVERR, "bad read");
    chk_data(got, BDM_ZERO32, "bad read data");
    // no byte strobe: accepted but nothing stored
    axi_wr({3'h0, BDM_STATUS_OFF, 2'h0}, 8'h20, 4'h0, rsp);
    chk_code(rsp, BDM_RESP_OKAY, "no strobe resp");
    chk_code(bank_o, BDM_BANK0, "no strobe bank");
    axi_rd({3'h0, BDM_STATUS_OFF, 2'h0}, got, rsp);
    chk_data(got, {24'h0, BDM_STATUS_RST}, "status kept");
    // pointer at the indirect port itself reads zero
    axi_rd({3'h0, BDM_IND_OFF, 2'h0}, got, rsp);
    chk_data(got, BDM_ZERO32, "self indirect");
    $display("refusal tests done");
    report_and_stop();
  end
endmodule
`default_nettype wire
